// file: pepb_counter.sv
/*
 Event selection and counting for software prefetch misses, prefetch
 collisions, data cache prefetch requests and bus occupancy events.
 Assumes all event inputs are single-cycle pulses from core logic on clk,
 and bus pins already sampled into clk. Pin inputs pass four flops.
*/
`timescale 1ns/1ps
`include "pepb_cfg.svh"
module pepb_counter (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic [7:0]             event_select,
   input  wire logic [7:0]             unit_mask,
   input  wire logic                   count_enable,
   input  wire logic                   count_clear,
   input  wire logic                   all_level_temporal_prefetch,
   input  wire logic                   second_level_temporal_prefetch,
   input  wire logic                   third_level_temporal_prefetch,
   input  wire logic                   prefetch_missed_all,
   input  wire logic                   load_hit_pending_prefetch,
   input  wire logic                   dcache_prefetch_request_event,
   input  wire logic                   line_read_issue,
   input  wire logic                   line_read_cacheable,
   input  wire logic                   line_read_from_data,
   input  wire logic                   line_read_other_core,
   input  wire logic                   line_read_done,
   input  wire logic                   line_read_done_other_core,
   input  wire logic                   stall_request,
   input  wire logic                   data_valid_pin,
   input  wire logic                   data_own_write,
   input  wire logic                   data_own_other_core,
   output logic                        bus_stall_signal,
   output logic [`PEPB_CNT_W-1:0]     event_count,
   output logic [`PEPB_PEND_W-1:0]    pending_reads
);
   logic [`PEPB_CNT_W-1:0]  cnt_r;
   logic [`PEPB_CNT_W-1:0]  cnt_nxt;
   logic [`PEPB_PEND_W-1:0] pend0_r;
   logic [`PEPB_PEND_W-1:0] pend0_nxt;
   logic [`PEPB_PEND_W-1:0] pend1_r;
   logic [`PEPB_PEND_W-1:0] pend1_nxt;
   logic [`PEPB_PEND_W-1:0] pend_r;
   logic [`PEPB_PEND_W-1:0] pend_nxt;
   logic [2:0]              dv_sync_r;
   logic [2:0]              dv_sync_nxt;
   logic                    dv_r;
   logic                    dv_nxt;
   logic                    not_ready_drive_event;
   logic                    t0_prefetch_miss_event;
   logic                    t1t2_prefetch_miss_event;
   logic                    data_ready_cycle_event;
   logic                    agent_all;
   logic [1:0]              core_sel;
   logic                    core_this_ok;
   logic                    core_other_ok;
   logic                    read_counted;
   logic [`PEPB_CNT_W-1:0]  incr;

   ////////////////////////////////////////////////////////////////////////
   // Stall driver
   pepb_stall_drv u_stall (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .stall_req             (stall_request),
      .bus_stall_signal      (bus_stall_signal),
      .not_ready_drive_event (not_ready_drive_event)
   );

   ////////////////////////////////////////////////////////////////////////
   // Qualifier decode
   always_comb begin
      agent_all     = unit_mask[`PEPB_UM_AGENT_BIT];
      core_sel      = unit_mask[`PEPB_UM_CORE_HI:`PEPB_UM_CORE_LO];
      core_this_ok  = (core_sel == `PEPB_CORE_THIS) || (core_sel == `PEPB_CORE_ALL);
      core_other_ok = (core_sel == `PEPB_CORE_ALL);
      // counted at execution, no retire gate
      t0_prefetch_miss_event   = all_level_temporal_prefetch && prefetch_missed_all;
      t1t2_prefetch_miss_event = (second_level_temporal_prefetch || third_level_temporal_prefetch)
                                 && prefetch_missed_all;
      read_counted = line_read_issue && line_read_cacheable && line_read_from_data;
      // own writes; any agent data; writing core in scope
      data_ready_cycle_event = dv_r && (agent_all
                               || (data_own_write && (data_own_other_core ? core_other_ok : core_this_ok)));
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling and pending read tracking
   always_comb begin
      dv_sync_nxt = {dv_sync_r[1:0], data_valid_pin};
      // Change accepted only when stages two and three agree
      dv_nxt      = (dv_sync_r[1] == dv_sync_r[2]) ? dv_sync_r[2] : dv_r;
      pend0_nxt   = pend0_r;
      pend1_nxt   = pend1_r;
      // pending from issue until full line received
      if (read_counted && !line_read_other_core) begin
         pend0_nxt = pend0_nxt + `PEPB_PEND_W'(1);
      end
      if (line_read_done && (pend0_r != '0)) begin
         pend0_nxt = pend0_nxt - `PEPB_PEND_W'(1);
      end
      if (read_counted && line_read_other_core) begin
         pend1_nxt = pend1_nxt + `PEPB_PEND_W'(1);
      end
      if (line_read_done_other_core && (pend1_r != '0)) begin
         pend1_nxt = pend1_nxt - `PEPB_PEND_W'(1);
      end
      pend_nxt = (core_this_ok ? pend0_nxt : '0) + (core_other_ok ? pend1_nxt : '0);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dv_sync_r <= 3'h0;
         dv_r      <= 1'b0;
         pend0_r   <= '0;
         pend1_r   <= '0;
         pend_r    <= '0;
      end else begin
         dv_sync_r <= dv_sync_nxt;
         dv_r      <= dv_nxt;
         pend0_r   <= pend0_nxt;
         pend1_r   <= pend1_nxt;
         pend_r    <= pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event select and counter
   always_comb begin
      incr = '0;
      case (event_select)
         `PEPB_EVT_SWPF_MISS: begin
            if (unit_mask == `PEPB_UM_T0) begin
               incr = `PEPB_CNT_W'(t0_prefetch_miss_event);
            end else if (unit_mask == `PEPB_UM_T1T2) begin
               incr = `PEPB_CNT_W'(t1t2_prefetch_miss_event);
            end
         end
         `PEPB_EVT_LOAD_HIT_PF: begin
            if (unit_mask == `PEPB_UM_NONE) begin
               incr = `PEPB_CNT_W'(load_hit_pending_prefetch);
            end
         end
         `PEPB_EVT_DC_PF_REQ: begin
            if (unit_mask == `PEPB_UM_DC_PF) begin
               incr = `PEPB_CNT_W'(dcache_prefetch_request_event);
            end
         end
         `PEPB_EVT_BUS_OUTST: begin
            incr = `PEPB_CNT_W'(pend_r);
         end
         `PEPB_EVT_BUS_STALL: begin
            incr = `PEPB_CNT_W'(not_ready_drive_event);
         end
         `PEPB_EVT_DATA_RDY: begin
            incr = `PEPB_CNT_W'(data_ready_cycle_event);
         end
         default: begin
            incr = '0;
         end
      endcase
      if (count_clear) begin
         cnt_nxt = `PEPB_CNT_RST;
      end else if (count_enable) begin
         cnt_nxt = cnt_r + incr;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= `PEPB_CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign event_count   = cnt_r;
   assign pending_reads = pend_r;

   property p_t0_count;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_SWPF_MISS && unit_mask == `PEPB_UM_T0
       && all_level_temporal_prefetch && prefetch_missed_all) |=> cnt_r == $past(cnt_r) + 1;
   endproperty
   a_t0_count: assert property (p_t0_count) else $error("t0 miss not counted");

   property p_t1t2_count;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_SWPF_MISS && unit_mask == `PEPB_UM_T1T2
       && third_level_temporal_prefetch && prefetch_missed_all) |=> cnt_r == $past(cnt_r) + 1;
   endproperty
   a_t1t2_count: assert property (p_t1t2_count) else $error("t1t2 miss not counted");

   property p_no_hit_no_count;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_SWPF_MISS && !prefetch_missed_all)
      |=> cnt_r == $past(cnt_r);
   endproperty
   a_no_hit_no_count: assert property (p_no_hit_no_count) else $error("counted a hit");

   property p_load_hit;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_LOAD_HIT_PF && unit_mask == `PEPB_UM_NONE
       && load_hit_pending_prefetch) |=> cnt_r == $past(cnt_r) + 1;
   endproperty
   a_load_hit: assert property (p_load_hit) else $error("load hit not counted");

   property p_dc_pf;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_DC_PF_REQ && unit_mask == `PEPB_UM_DC_PF
       && dcache_prefetch_request_event) |=> cnt_r == $past(cnt_r) + 1;
   endproperty
   a_dc_pf: assert property (p_dc_pf) else $error("prefetch request lost");

   property p_outst_add;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_BUS_OUTST)
      |=> cnt_r == $past(cnt_r) + `PEPB_CNT_W'($past(pend_r));
   endproperty
   a_outst_add: assert property (p_outst_add) else $error("pending sum wrong");

   property p_rfo_excluded;
      @(posedge clk) disable iff (sys_rst)
      (line_read_issue && !line_read_cacheable && !line_read_done && !line_read_other_core)
      |=> pend0_r == $past(pend0_r);
   endproperty
   a_rfo_excluded: assert property (p_rfo_excluded) else $error("excluded read pended");

   property p_data_valid_signal_all;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_DATA_RDY && agent_all && dv_r)
      |=> cnt_r == $past(cnt_r) + 1;
   endproperty
   a_data_valid_signal_all: assert property (p_data_valid_signal_all) else $error("data cycle lost");

   property p_data_valid_signal_own;
      @(posedge clk) disable iff (sys_rst)
      (count_enable && !count_clear && event_select == `PEPB_EVT_DATA_RDY && !agent_all && dv_r
       && !data_own_write) |=> cnt_r == $past(cnt_r);
   endproperty
   a_data_valid_signal_own: assert property (p_data_valid_signal_own) else $error("foreign data counted");
endmodule

// file: pepb_cfg.svh
/*
 Constants for the prefetch and bus event counter: event numbers, unit masks,
 qualifier bit positions, widths and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PEPB_CFG_SVH
`define PEPB_CFG_SVH
`define PEPB_EVT_SWPF_MISS   8'h4B
`define PEPB_EVT_LOAD_HIT_PF 8'h4C
`define PEPB_EVT_DC_PF_REQ   8'h4E
`define PEPB_EVT_BUS_OUTST   8'h60
`define PEPB_EVT_BUS_STALL   8'h61
`define PEPB_EVT_DATA_RDY    8'h62
`define PEPB_UM_T0           8'h01
`define PEPB_UM_T1T2         8'h02
`define PEPB_UM_NONE         8'h00
`define PEPB_UM_DC_PF        8'h10
`define PEPB_UM_AGENT_BIT    5
`define PEPB_UM_CORE_HI      7
`define PEPB_UM_CORE_LO      6
`define PEPB_CORE_THIS       2'h1
`define PEPB_CORE_ALL        2'h3
`define PEPB_CNT_W           40
`define PEPB_CNT_RST         40'h00_0000_0000
`define PEPB_PEND_W          4
`define PEPB_STALL_CYC       2'h2
`endif

// file: pepb_pkg.sv
/*
 Types for the prefetch and bus event counter.
 Assumes pepb_cfg.svh is visible to the compile unit.
*/
package pepb_pkg;
   typedef enum logic [2:0] {
      PEPB_ST_IDLE  = 3'b001,
      PEPB_ST_HOLD1 = 3'b010,
      PEPB_ST_HOLD2 = 3'b100
   } pepb_stall_st_t;
endpackage

// file: pepb_stall_drv.sv
/*
 Bus stall driver: asserts the stall signal for exactly two bus cycles per
 request and reports one event per assertion.
 Assumes the request comes from logic on the same clock.
*/
`timescale 1ns/1ps
`include "pepb_cfg.svh"
module pepb_stall_drv (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic stall_req,
   output logic      bus_stall_signal,
   output logic      not_ready_drive_event
);
   pepb_pkg::pepb_stall_st_t st_r;
   pepb_pkg::pepb_stall_st_t st_nxt;
   logic                     stall_r;
   logic                     stall_nxt;
   logic                     ev_r;
   logic                     ev_nxt;

   ////////////////////////////////////////////////////////////////////////
   // two-cycle assertion
   always_comb begin
      st_nxt    = st_r;
      stall_nxt = 1'b0;
      ev_nxt    = 1'b0;
      case (st_r)
         pepb_pkg::PEPB_ST_IDLE: begin
            if (stall_req) begin
               st_nxt    = pepb_pkg::PEPB_ST_HOLD1;
               stall_nxt = 1'b1;
               ev_nxt    = 1'b1;
            end
         end
         pepb_pkg::PEPB_ST_HOLD1: begin
            st_nxt    = pepb_pkg::PEPB_ST_HOLD2;
            stall_nxt = 1'b1;
         end
         pepb_pkg::PEPB_ST_HOLD2: begin
            st_nxt = pepb_pkg::PEPB_ST_IDLE;
         end
         default: begin
            st_nxt = pepb_pkg::PEPB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r    <= pepb_pkg::PEPB_ST_IDLE;
         stall_r <= 1'b0;
         ev_r    <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         stall_r <= stall_nxt;
         ev_r    <= ev_nxt;
      end
   end

   assign bus_stall_signal      = stall_r;
   assign not_ready_drive_event = ev_r;

   property p_stall_two;
      @(posedge clk) disable iff (sys_rst)
      $rose(stall_r) |-> stall_r ##1 stall_r ##1 !stall_r;
   endproperty
   a_stall_two: assert property (p_stall_two) else $error("stall not two cycles");

   property p_event_on_rise;
      @(posedge clk) disable iff (sys_rst)
      ev_r == $rose(stall_r);
   endproperty
   a_event_on_rise: assert property (p_event_on_rise) else $error("stall event mismatch");
endmodule

// file: pepb_bus_agent.sv
/*
 Model of the other bus agents: drives the data-ready pin for one burst.
 Assumes the bench holds go until busy rises, then drops it.
*/
`timescale 1ns/1ps
module pepb_bus_agent (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       bus_stall_signal,
   input  wire logic       go,
   input  wire logic [3:0] n_beats,
   output logic            data_valid_pin,
   output logic            busy
);
   logic [3:0] beat_r;
   always_ff @(posedge clk) begin
      if (sys_rst)
         beat_r <= 4'h0;
      else if (beat_r == 4'h0 && go && !bus_stall_signal)
         beat_r <= n_beats;
      else if (beat_r != 4'h0)
         beat_r <= beat_r - 4'h1;
   end
   // Pin pulled low between bursts
   assign data_valid_pin = (beat_r != 4'h0);
   assign busy = (beat_r != 4'h0);
endmodule

// file: test_perf_event_prefetch_bus_counting.sv
/*
 Self-checking bench for the prefetch and bus event counter.
 Assumes pepb_cfg.svh and the bus agent model are compiled alongside.
*/
`timescale 1ns/1ps
`include "pepb_cfg.svh"
module test_perf_event_prefetch_bus_counting;
   logic        clk, sys_rst, count_enable, count_clear, stall_request, bus_stall_signal;
   logic        all_level_temporal_prefetch, second_level_temporal_prefetch, third_level_temporal_prefetch;
   logic        prefetch_missed_all, load_hit_pending_prefetch, dcache_prefetch_request_event;
   logic        line_read_issue, line_read_cacheable, line_read_from_data, line_read_other_core;
   logic        line_read_done, line_read_done_other_core, data_valid_pin, data_own_write;
   logic        agent_go, agent_busy, data_own_other_core;
   logic [3:0]  agent_beats;
   logic [7:0]  event_select, unit_mask;
   logic [39:0] event_count;
   logic [3:0]  pending_reads;
   int          err_count = 0;
   int          n_compared = 0;
   int          stall_cycles = 0;

   pepb_counter i_dut (.clk, .sys_rst, .event_select, .unit_mask, .count_enable, .count_clear,
      .all_level_temporal_prefetch, .second_level_temporal_prefetch, .third_level_temporal_prefetch,
      .prefetch_missed_all, .load_hit_pending_prefetch, .dcache_prefetch_request_event,
      .line_read_issue, .line_read_cacheable, .line_read_from_data, .line_read_other_core,
      .line_read_done, .line_read_done_other_core, .stall_request, .data_valid_pin,
      .data_own_write, .data_own_other_core, .bus_stall_signal, .event_count, .pending_reads);
   pepb_bus_agent i_agent (.clk, .sys_rst, .bus_stall_signal, .go(agent_go), .n_beats(agent_beats),
      .data_valid_pin, .busy(agent_busy));

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (bus_stall_signal === 1'h1)
         stall_cycles <= stall_cycles + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic cnt_chk(input string nm, input logic [39:0] exp);
      tick(3);
      #1;
      chk(nm, event_count, exp);
   endtask
   task automatic sel(input logic [7:0] ev, input logic [7:0] um, input logic en);
      @(posedge clk);
      event_select <= ev;
      unit_mask <= um;
      count_clear <= 1'h1;
      @(posedge clk);
      count_clear <= 1'h0;
      count_enable <= en;
   endtask
   // Bits are all-level, second, third, missed
   task automatic pf(input logic [3:0] k, input int n);
      @(posedge clk);
      {all_level_temporal_prefetch, second_level_temporal_prefetch} <= k[3:2];
      {third_level_temporal_prefetch, prefetch_missed_all} <= k[1:0];
      tick(n);
      {all_level_temporal_prefetch, second_level_temporal_prefetch} <= 2'h0;
      {third_level_temporal_prefetch, prefetch_missed_all} <= 2'h0;
   endtask
   task automatic burst(input logic [3:0] n, input logic own);
      @(posedge clk);
      data_own_write <= own;
      agent_go <= 1'h1;
      agent_beats <= n;
      for (int i = 0; i < 40 && agent_busy !== 1'h1; i++) @(posedge clk);
      agent_go <= 1'h0;
      // Pin goes through a three-flop sampler
      tick(12);
      data_own_write <= 1'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // prefetch miss selection
   task automatic t_prefetch;
      sel(`PEPB_EVT_SWPF_MISS, `PEPB_UM_T0, 1'h1);
      pf(4'h9, 3);
      pf(4'h8, 2);
      pf(4'h5, 1);
      cnt_chk("t0 miss count", 40'h3);
      sel(`PEPB_EVT_SWPF_MISS, `PEPB_UM_T1T2, 1'h1);
      pf(4'h5, 2);
      pf(4'h3, 1);
      pf(4'h9, 1);
      pf(4'h4, 2);
      cnt_chk("t1t2 miss count", 40'h3);
      $display("test prefetch done");
   endtask
   task automatic t_local;
      sel(`PEPB_EVT_LOAD_HIT_PF, `PEPB_UM_NONE, 1'h1);
      @(posedge clk);
      load_hit_pending_prefetch <= 1'h1;
      dcache_prefetch_request_event <= 1'h1;
      tick(4);
      load_hit_pending_prefetch <= 1'h0;
      cnt_chk("load hit count", 40'h4);
      sel(`PEPB_EVT_DC_PF_REQ, `PEPB_UM_DC_PF, 1'h1);
      cnt_chk("dcache request count", 40'h3);
      sel(`PEPB_EVT_DC_PF_REQ, `PEPB_UM_NONE, 1'h1);
      // Requests keep coming so a wrong mask would count
      cnt_chk("unmatched mask count", 40'h0);
      dcache_prefetch_request_event <= 1'h0;
      $display("test local done");
   endtask
   task automatic t_pending;
      logic [2:0] q [5];
      q = '{3'h6, 3'h2, 3'h4, 3'h7, 3'h6};
      sel(`PEPB_EVT_BUS_OUTST, 8'h40, 1'h0);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         line_read_issue <= 1'h1;
         {line_read_cacheable, line_read_from_data, line_read_other_core} <= q[i];
      end
      @(posedge clk);
      line_read_issue <= 1'h0;
      tick(2);
      #1;
      chk("pending reads", {36'h0, pending_reads}, 40'h2);
      @(posedge clk);
      count_enable <= 1'h1;
      tick(5);
      count_enable <= 1'h0;
      cnt_chk("outstanding sum", 40'hA);
      @(posedge clk);
      line_read_done_other_core <= 1'h1;
      @(posedge clk);
      line_read_done_other_core <= 1'h0;
      line_read_done <= 1'h1;
      tick(3);
      line_read_done <= 1'h0;
      tick(2);
      #1;
      chk("pending after done", {36'h0, pending_reads}, 40'h0);
      $display("test pending done");
   endtask
   task automatic t_stall;
      int base;
      sel(`PEPB_EVT_BUS_STALL, `PEPB_UM_NONE, 1'h1);
      base = stall_cycles;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         stall_request <= 1'h1;
         tick(2);
         stall_request <= 1'h0;
         tick(2);
      end
      cnt_chk("stall events", 40'h3);
      chk("stall cycles", 40'(stall_cycles - base), 40'h6);
      $display("test stall done");
   endtask
   task automatic t_data_valid_signal;
      sel(`PEPB_EVT_DATA_RDY, 8'h40, 1'h1);
      burst(4'h4, 1'h1);
      burst(4'h3, 1'h0);
      // Own write from the other core is out of scope
      data_own_other_core <= 1'h1;
      burst(4'h2, 1'h1);
      data_own_other_core <= 1'h0;
      cnt_chk("own data cycles", 40'h4);
      sel(`PEPB_EVT_DATA_RDY, 8'h60, 1'h1);
      stall_request <= 1'h1;
      @(posedge clk);
      stall_request <= 1'h0;
      burst(4'h3, 1'h0);
      burst(4'h2, 1'h1);
      cnt_chk("all data cycles", 40'h5);
      $display("test data ready done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      {sys_rst, count_enable, count_clear, stall_request, data_own_write, agent_go} = 6'h20;
      {all_level_temporal_prefetch, second_level_temporal_prefetch, third_level_temporal_prefetch} = 3'h0;
      {prefetch_missed_all, load_hit_pending_prefetch, dcache_prefetch_request_event} = 3'h0;
      {line_read_issue, line_read_cacheable, line_read_from_data, line_read_other_core} = 4'h0;
      {line_read_done, line_read_done_other_core} = 2'h0;
      data_own_other_core = 1'h0;
      {event_select, unit_mask, agent_beats} = 20'h0;
      tick(4);
      sys_rst <= 1'h0;
      t_prefetch;
      t_local;
      t_pending;
      t_stall;
      t_data_valid_signal;
      conclude;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      tick(3000);
      err_count++;
      conclude;
   end
endmodule
